// file: rtl/sscx_pkg.sv
// Behaviour
// - A byte store writes only the low 8 bits of the second source as a one-byte write.
// - A halfword store writes only the low 16 bits of the second source as a two-byte write.
// - A store address is the first source plus the sign-extended 12-bit offset.
// - A byte store is decoded as S-type with minor opcode 000 and major opcode 0100011.
// - A store address is translated for a data write first; a failure raises a memory exception with the virtual address and fails the instruction.
// - After translation the write address and size are announced first; an exception there aborts the store.
// - The second source is captured at issue; only after a good announcement is its truncated value sent to the physical address.
// - A memory exception on either store step raises an exception with the virtual address and fails the instruction.
// - A halfword store announces a two-byte write after translation and before the value.
// - The shift-left fills with zeros and takes its amount from the low 5 bits of the second source.
// - The signed compare writes 1 when the first source is below the second as signed values, else 0.
// - The immediate compare writes 1 when the first source is below the sign-extended immediate, else 0.
// - The immediate compare is decoded as I-type with minor opcode 010 and major opcode 0010011.
// - A halfword store uses the common store layout, base from rs1 and data from rs2.
package sscx_pkg;

  localparam int XLEN = 32;
  localparam int SHAMT_W = 5;
  localparam int BYTE_W = 8;
  localparam int HALF_W = 16;
  localparam int SIZE_W = 3;

  localparam logic [6:0] OPC_STORE = 7'h23;
  localparam logic [6:0] OPC_REG = 7'h33;
  localparam logic [6:0] OPC_IMM = 7'h13;
  localparam logic [6:0] UPPER_BASE = 7'h00;
  localparam logic [2:0] MINOR_BYTE = 3'h0;
  localparam logic [2:0] MINOR_HALF = 3'h1;
  localparam logic [2:0] MINOR_SHL = 3'h1;
  localparam logic [2:0] MINOR_SLT = 3'h2;
  localparam logic [SIZE_W-1:0] SIZE_BYTE = 3'h1;
  localparam logic [SIZE_W-1:0] SIZE_HALF = 3'h2;
  localparam logic [4:0] ZERO_REG = 5'h00;
  localparam logic [XLEN-1:0] WORD_RESET = 32'h0000_0000;

  typedef enum logic [2:0] {OP_NONE, OP_SB, OP_SH, OP_SHL, OP_SLT, OP_SLTI} sscx_op_t;

  // Instruction word layout; field positions follow from the member order
  typedef struct packed {
    logic [6:0] upper_function_field;
    logic [4:0] rs2;
    logic [4:0] rs1;
    logic [2:0] minor_opcode_field;
    logic [4:0] rd;
    logic [6:0] opcode;
  } sscx_word_t;

  typedef struct packed {
    sscx_op_t op;
    logic [4:0] rd;
    logic [XLEN-1:0] imm;
  } sscx_dec_t;

  typedef struct packed {
    logic [XLEN-1:0] addr;
    logic [SIZE_W-1:0] size;
  } sscx_mem_req_t;

  // Sign-extend a 12-bit immediate to the register width
  function automatic logic [XLEN-1:0] sext12(input logic [11:0] v);
    return {{(XLEN-12){v[11]}}, v};
  endfunction : sext12

  // Decode one instruction word into operation, destination and immediate
  function automatic sscx_dec_t decode(input sscx_word_t w);
    sscx_dec_t d;
    d.op = OP_NONE;
    d.rd = w.rd;
    d.imm = sext12({w.upper_function_field, w.rs2});
    unique case (w.opcode)
      OPC_STORE: begin
        // Offset halves sit in the upper-function and rd positions
        d.imm = sext12({w.upper_function_field, w.rd});
        if (w.minor_opcode_field == MINOR_BYTE) d.op = OP_SB;
        if (w.minor_opcode_field == MINOR_HALF) d.op = OP_SH;
      end
      OPC_REG: begin
        if (w.upper_function_field == UPPER_BASE && w.minor_opcode_field == MINOR_SHL)
          d.op = OP_SHL;
        if (w.upper_function_field == UPPER_BASE && w.minor_opcode_field == MINOR_SLT)
          d.op = OP_SLT;
      end
      OPC_IMM: begin
        if (w.minor_opcode_field == MINOR_SLT) d.op = OP_SLTI;
      end
      default: d.op = OP_NONE;
    endcase
    return d;
  endfunction : decode

endpackage : sscx_pkg

// file: rtl/sscx_alu.sv
`timescale 1ns/1ps
`default_nettype none
// Shift and compare datapath, purely combinational
module sscx_alu (
  input wire sscx_pkg::sscx_op_t i_op,
  input wire logic [sscx_pkg::XLEN-1:0] i_src_a,
  input wire logic [sscx_pkg::XLEN-1:0] i_src_b,
  input wire logic [sscx_pkg::XLEN-1:0] i_imm,
  output logic [sscx_pkg::XLEN-1:0] o_result
);

  // Result select per operation
  always_comb begin
    o_result = sscx_pkg::WORD_RESET;
    unique case (i_op)
      sscx_pkg::OP_SHL:
        o_result = i_src_a << i_src_b[sscx_pkg::SHAMT_W-1:0];
      sscx_pkg::OP_SLT:
        o_result = {{(sscx_pkg::XLEN-1){1'b0}},
                    $signed(i_src_a) < $signed(i_src_b)};
      sscx_pkg::OP_SLTI:
        o_result = {{(sscx_pkg::XLEN-1){1'b0}},
                    $signed(i_src_a) < $signed(i_imm)};
      default: o_result = sscx_pkg::WORD_RESET;
    endcase
  end

endmodule : sscx_alu
`default_nettype wire

// file: rtl/sscx_exec.sv
`timescale 1ns/1ps
`default_nettype none
// Decode and execute for byte/halfword store, shift-left and signed compares
module sscx_exec (
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  // Issue port
  input wire logic i_issue_valid,
  output logic o_issue_ready,
  input wire logic [sscx_pkg::XLEN-1:0] i_instr,
  input wire logic [sscx_pkg::XLEN-1:0] i_rs1_val,
  input wire logic [sscx_pkg::XLEN-1:0] i_rs2_val,
  // Address translation
  output logic o_xlat_valid,
  output logic [sscx_pkg::XLEN-1:0] o_xlat_vaddr,
  input wire logic i_xlat_done,
  input wire logic i_xlat_fault,
  input wire logic [sscx_pkg::XLEN-1:0] i_xlat_paddr,
  // Write address announcement
  output logic o_mem_ea_valid,
  output sscx_pkg::sscx_mem_req_t o_mem_ea,
  input wire logic i_mem_ea_done,
  input wire logic i_mem_ea_exc,
  // Write value
  output logic o_mem_wr_valid,
  output logic [sscx_pkg::XLEN-1:0] o_mem_wr_data,
  input wire logic i_mem_wr_done,
  input wire logic i_mem_wr_exc,
  // Destination write and completion
  output logic o_rd_we,
  output logic [4:0] o_rd_addr,
  output logic [sscx_pkg::XLEN-1:0] o_rd_data,
  output logic o_retire,
  output logic o_fail,
  output logic o_illegal,
  output logic o_exc_valid,
  output logic [sscx_pkg::XLEN-1:0] o_exc_vaddr
);

  typedef enum logic [1:0] {ST_IDLE, ST_XLAT, ST_ANNOUNCE, ST_SEND} sscx_state_t;

  sscx_state_t state_r;
  sscx_pkg::sscx_dec_t dec;
  sscx_pkg::sscx_op_t op_r;
  logic [sscx_pkg::XLEN-1:0] rs2_r;
  logic [sscx_pkg::XLEN-1:0] alu_res;
  logic issue;
  logic xlat_bad;
  logic ea_bad;
  logic wr_bad;

  assign dec = sscx_pkg::decode(i_instr);
  assign o_issue_ready = (state_r == ST_IDLE);
  assign issue = i_issue_valid && o_issue_ready;
  assign o_xlat_valid = (state_r == ST_XLAT);
  assign o_mem_ea_valid = (state_r == ST_ANNOUNCE);
  assign o_mem_wr_valid = (state_r == ST_SEND);
  assign xlat_bad = o_xlat_valid && i_xlat_done && i_xlat_fault;
  assign ea_bad = o_mem_ea_valid && i_mem_ea_done && i_mem_ea_exc;
  assign wr_bad = o_mem_wr_valid && i_mem_wr_done && i_mem_wr_exc;

  sscx_alu u_alu (
    .i_op(dec.op),
    .i_src_a(i_rs1_val),
    .i_src_b(i_rs2_val),
    .i_imm(dec.imm),
    .o_result(alu_res)
  );

  // Store sequence: translate, announce, send
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_r <= ST_IDLE;
    end else begin
      unique case (state_r)
        ST_IDLE:
          if (issue && (dec.op == sscx_pkg::OP_SB || dec.op == sscx_pkg::OP_SH))
            state_r <= ST_XLAT;
        ST_XLAT:
          if (i_xlat_done) state_r <= i_xlat_fault ? ST_IDLE : ST_ANNOUNCE;
        ST_ANNOUNCE:
          if (i_mem_ea_done) state_r <= i_mem_ea_exc ? ST_IDLE : ST_SEND;
        ST_SEND:
          if (i_mem_wr_done) state_r <= ST_IDLE;
      endcase
    end
  end

  // Store operands captured at issue
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      op_r <= sscx_pkg::OP_NONE;
      o_xlat_vaddr <= sscx_pkg::WORD_RESET;
      rs2_r <= sscx_pkg::WORD_RESET;
    end else if (issue) begin
      op_r <= dec.op;
      o_xlat_vaddr <= i_rs1_val + dec.imm;
      rs2_r <= i_rs2_val;
    end
  end

  // Physical address and access size for the announcement
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_mem_ea <= '0;
    end else if (o_xlat_valid && i_xlat_done && !i_xlat_fault) begin
      o_mem_ea.addr <= i_xlat_paddr;
      o_mem_ea.size <= (op_r == sscx_pkg::OP_SB) ? sscx_pkg::SIZE_BYTE
                                                 : sscx_pkg::SIZE_HALF;
    end
  end

  // Store value formed only once the announcement is accepted
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_mem_wr_data <= sscx_pkg::WORD_RESET;
    end else if (o_mem_ea_valid && i_mem_ea_done && !i_mem_ea_exc) begin
      if (op_r == sscx_pkg::OP_SB)
        o_mem_wr_data <= {{(sscx_pkg::XLEN-sscx_pkg::BYTE_W){1'b0}},
                          rs2_r[sscx_pkg::BYTE_W-1:0]};
      else
        o_mem_wr_data <= {{(sscx_pkg::XLEN-sscx_pkg::HALF_W){1'b0}},
                          rs2_r[sscx_pkg::HALF_W-1:0]};
    end
  end

  // Destination write for shift and compares
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_rd_we <= 1'b0;
      o_rd_addr <= sscx_pkg::ZERO_REG;
      o_rd_data <= sscx_pkg::WORD_RESET;
    end else begin
      o_rd_we <= issue && dec.rd != sscx_pkg::ZERO_REG && (dec.op == sscx_pkg::OP_SHL
                 || dec.op == sscx_pkg::OP_SLT || dec.op == sscx_pkg::OP_SLTI);
      if (issue) begin
        o_rd_addr <= dec.rd;
        o_rd_data <= alu_res;
      end
    end
  end

  // Completion pulses and exception report
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_retire <= 1'b0;
      o_fail <= 1'b0;
      o_illegal <= 1'b0;
      o_exc_valid <= 1'b0;
      o_exc_vaddr <= sscx_pkg::WORD_RESET;
    end else begin
      o_retire <= (issue && (dec.op == sscx_pkg::OP_SHL || dec.op == sscx_pkg::OP_SLT
                   || dec.op == sscx_pkg::OP_SLTI))
                  || (o_mem_wr_valid && i_mem_wr_done && !i_mem_wr_exc);
      o_illegal <= issue && dec.op == sscx_pkg::OP_NONE;
      o_fail <= xlat_bad || ea_bad || wr_bad;
      o_exc_valid <= xlat_bad || ea_bad || wr_bad;
      if (xlat_bad || ea_bad || wr_bad)
        o_exc_vaddr <= o_xlat_vaddr;
    end
  end

  // Checks
  chk_byte_trunc: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    o_mem_wr_valid && op_r == sscx_pkg::OP_SB |-> o_mem_wr_data == {24'h000000, rs2_r[7:0]})
    else $error("byte store value not truncated to 8 bits");
  chk_half_trunc: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    o_mem_wr_valid && op_r == sscx_pkg::OP_SH |-> o_mem_wr_data == {16'h0000, rs2_r[15:0]})
    else $error("halfword store value not truncated to 16 bits");
  chk_store_addr: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    issue && dec.op == sscx_pkg::OP_SB |=> o_xlat_valid
      && o_xlat_vaddr == $past(i_rs1_val) + {{20{$past(i_instr[31])}}, $past(i_instr[31:25]),
                         $past(i_instr[11:7])})
    else $error("store address differs from base plus offset");
  chk_xlat_fault: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    xlat_bad |=> o_fail && o_exc_valid && !o_retire && o_exc_vaddr == $past(o_xlat_vaddr)
      ##1 !o_mem_ea_valid)
    else $error("translation fault not reported or store went on");
  chk_byte_size: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    o_mem_ea_valid && op_r == sscx_pkg::OP_SB |-> o_mem_ea.size == 3'h1)
    else $error("byte store announced with wrong size");
  chk_half_size: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    o_mem_ea_valid && op_r == sscx_pkg::OP_SH |-> o_mem_ea.size == 3'h2)
    else $error("halfword store announced with wrong size");
  chk_announce_first: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    $rose(o_mem_wr_valid) |-> $past(o_mem_ea_valid && i_mem_ea_done && !i_mem_ea_exc))
    else $error("store value sent without accepted announcement");
  chk_mem_exc: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    (ea_bad || wr_bad) |=> o_fail && !o_retire && o_exc_vaddr == $past(o_xlat_vaddr)
      && o_issue_ready)
    else $error("memory exception not reported as failure");
  chk_shift_left: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    issue && dec.op == sscx_pkg::OP_SHL |=> o_rd_data == $past(i_rs1_val) << $past(i_rs2_val[4:0]))
    else $error("shift-left result wrong");
  chk_slt_value: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    issue && dec.op == sscx_pkg::OP_SLT |=> o_rd_data == {31'h0, $past($signed(i_rs1_val)
      < $signed(i_rs2_val))} && o_retire)
    else $error("signed compare result wrong");
  chk_slti_value: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    issue && dec.op == sscx_pkg::OP_SLTI |=> o_rd_data == {31'h0, $past($signed(i_rs1_val)
      < $signed({{20{i_instr[31]}}, i_instr[31:20]}))})
    else $error("immediate compare result wrong");
  chk_zero_dest: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    o_rd_we |-> o_rd_addr != 5'h00 && $past(issue))
    else $error("write to register zero or without issue");
  chk_paddr_used: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    $rose(o_mem_ea_valid) |-> o_mem_ea.addr == $past(i_xlat_paddr))
    else $error("announced address differs from translated address");
  chk_unknown_word: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    issue && dec.op == sscx_pkg::OP_NONE |=> o_illegal && !o_retire && !o_fail && !o_rd_we)
    else $error("unknown word not reported as illegal");
  chk_store_no_rd: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    issue && (dec.op == sscx_pkg::OP_SB || dec.op == sscx_pkg::OP_SH) |=> !o_rd_we)
    else $error("store wrote a destination register");

endmodule : sscx_exec
`default_nettype wire

// file: bench/sscx_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
// Translation and data-memory stand-in, answering each store step in turn
module sscx_mem_model #(
  parameter logic [31:0] PA_XOR = 32'h4000_0000
) (
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  input wire logic i_xlat_valid,
  input wire logic [31:0] i_xlat_vaddr,
  input wire logic i_ea_valid,
  input wire logic i_wr_valid,
  input wire logic [1:0] i_delay,
  input wire logic [1:0] i_fault_step,
  output logic o_xlat_done,
  output logic o_xlat_fault,
  output logic [31:0] o_xlat_paddr,
  output logic o_ea_done,
  output logic o_ea_exc,
  output logic o_wr_done,
  output logic o_wr_exc
);
  logic [1:0] wait_r;
  logic [2:0] done_r;
  logic [31:0] pa_r;
  logic noise_r;
  // Count the wait, then pulse the answer of whichever step is asked
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wait_r <= 2'h0;
      done_r <= 3'h0;
      pa_r <= 32'h0;
      noise_r <= 1'b0;
    end else begin
      noise_r <= ~noise_r;
      if (i_xlat_valid) pa_r <= i_xlat_vaddr ^ PA_XOR;
      if (|done_r) begin
        done_r <= 3'h0;
        wait_r <= 2'h0;
      end else if (i_xlat_valid | i_ea_valid | i_wr_valid) begin
        if (wait_r == i_delay) done_r <= {i_wr_valid, i_ea_valid, i_xlat_valid};
        else wait_r <= wait_r + 2'h1;
      end
    end
  end
  // Answer lines carry meaning only with their pulse; otherwise they toggle
  assign o_xlat_done = done_r[0];
  assign o_xlat_fault = done_r[0] ? (i_fault_step == 2'h1) : noise_r;
  assign o_xlat_paddr = done_r[0] ? pa_r : pa_r ^ {32{noise_r}};
  assign o_ea_done = done_r[1];
  assign o_ea_exc = done_r[1] ? (i_fault_step == 2'h2) : noise_r;
  assign o_wr_done = done_r[2];
  assign o_wr_exc = done_r[2] ? (i_fault_step == 2'h3) : noise_r;
endmodule : sscx_mem_model
`default_nettype wire

// file: bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
// Issues random and corner instructions and checks every completion
module testbench;
  localparam logic [31:0] PA_XOR = 32'h4000_0000;
  typedef struct {
    logic ret, fail, ill, we;
    logic [4:0] rd;
    logic [31:0] data, va, wd;
    logic [34:0] ea;
    int st;
  } sscx_note_t;
  logic clk, rst_b, valid, ready, xv, xd, xf, eav, ead, eae, wrv, wrd, wre;
  logic rd_we, retire, fail, illegal, exc_v, ea_h, wr_h;
  logic [31:0] instr, a, b, xva, xpa, wdat, rdat, exc_va, va_s, wd_s;
  logic [4:0] rd_addr;
  logic [1:0] dly, fs;
  sscx_pkg::sscx_mem_req_t ea, ea_s;
  sscx_note_t notes[$];
  sscx_note_t n, m;
  int bad_count, n_compared;
  sscx_exec dut (.i_core_clk(clk), .i_rst_b(rst_b), .i_issue_valid(valid), .o_issue_ready(ready),
    .i_instr(instr), .i_rs1_val(a), .i_rs2_val(b), .o_xlat_valid(xv), .o_xlat_vaddr(xva),
    .i_xlat_done(xd), .i_xlat_fault(xf), .i_xlat_paddr(xpa), .o_mem_ea_valid(eav),
    .o_mem_ea(ea), .i_mem_ea_done(ead), .i_mem_ea_exc(eae), .o_mem_wr_valid(wrv),
    .o_mem_wr_data(wdat), .i_mem_wr_done(wrd), .i_mem_wr_exc(wre), .o_rd_we(rd_we),
    .o_rd_addr(rd_addr), .o_rd_data(rdat), .o_retire(retire), .o_fail(fail),
    .o_illegal(illegal), .o_exc_valid(exc_v), .o_exc_vaddr(exc_va));
  sscx_mem_model #(.PA_XOR(PA_XOR)) mem (.i_core_clk(clk), .i_rst_b(rst_b),
    .i_xlat_valid(xv), .i_xlat_vaddr(xva), .i_ea_valid(eav), .i_wr_valid(wrv),
    .i_delay(dly), .i_fault_step(fs), .o_xlat_done(xd), .o_xlat_fault(xf),
    .o_xlat_paddr(xpa), .o_ea_done(ead), .o_ea_exc(eae), .o_wr_done(wrd), .o_wr_exc(wre));
  // Compare one value and count it
  task automatic check(input string name, input logic [34:0] seen, input logic [34:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic print_verdict();
    $display("Compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : print_verdict
  // Offer one instruction at a falling edge, hold it over the taking edge, then withdraw it
  // so that the same word is never taken a second time with the next operands
  task automatic issue(input logic [31:0] w, input sscx_note_t e);
    int guard;
    guard = 0;
    while (ready !== 1'b1 && guard < 100) begin
      @(negedge clk);
      guard++;
    end
    valid = 1'b1;
    instr = w;
    notes.push_back(e);
    @(negedge clk);
    valid = 1'b0;
  endtask : issue
  // Clock generator
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Watchdog
  initial begin
    #(6000 * 25);
    bad_count++;
    print_verdict();
  end
  // Capture store traffic and compare each completion with the oldest note
  always @(negedge clk) begin
    if (xv) va_s = xva;
    if (eav) begin
      ea_s = ea;
      ea_h = 1'b1;
    end
    if (wrv) begin
      wd_s = wdat;
      wr_h = 1'b1;
    end
    if (retire === 1'b1 || fail === 1'b1 || illegal === 1'b1) begin
      if (notes.size() == 0) check("unexpected completion", 35'h1, 35'h0);
      else begin
        m = notes.pop_front();
        check("status", {retire, fail, illegal}, {m.ret, m.fail, m.ill});
        check("rd write", rd_we, m.we);
        if (m.we) check("rd addr", rd_addr, m.rd);
        if (m.we) check("rd data", rdat, m.data);
        if (m.st > 0) check("vaddr", va_s, m.va);
        check("announce reached", ea_h, m.st >= 2);
        check("value reached", wr_h, m.st == 3);
        if (m.st >= 2) check("announce", ea_s, m.ea);
        if (m.st == 3) check("store data", wd_s, m.wd);
        check("exception", exc_v, m.fail);
        if (m.fail) check("exc vaddr", exc_va, m.va);
      end
      ea_h = 1'b0;
      wr_h = 1'b0;
    end
  end
  // Main sequence: every operation twice, then random mixes
  initial begin
    logic [31:0] w, sx;
    logic [11:0] imm;
    logic [4:0] rd, r1, r2;
    int op;
    bad_count = 0; n_compared = 0; ea_h = 1'b0; wr_h = 1'b0;
    rst_b = 1'b0; valid = 1'b0; instr = 32'h0; a = 32'h0; b = 32'h0; dly = 2'h0; fs = 2'h0;
    void'($urandom(32'h5ee9f62c));
    repeat (12) @(posedge clk);
    @(negedge clk) rst_b = 1'b1;
    for (int i = 0; i < 80; i++) begin
      op = (i < 12) ? i % 6 : $urandom_range(5, 0);
      imm = $urandom; rd = (i % 5 == 2) ? 5'h0 : 5'($urandom);
      r1 = $urandom; r2 = $urandom;
      sx = {{20{imm[11]}}, imm};
      n = '{default: '0};
      n.rd = rd;
      @(negedge clk);
      while (ready !== 1'b1) @(negedge clk);
      a = $urandom; b = $urandom;
      if (i == 8 || i == 9) begin a = 32'h8000_0000; b = 32'h7fff_ffff; end
      if (i == 10) begin a = 32'h7fff_ffff; imm = 12'h800; sx = 32'hffff_f800; end
      dly = $urandom_range(3, 0);
      fs = (op < 2) ? 2'($urandom_range(3, 0)) : 2'h0;
      n.va = a + sx;
      case (op)
        0: begin
          w = {imm[11:5], r2, r1, 3'h0, imm[4:0], 7'h23};
          n.ea = {n.va ^ PA_XOR, sscx_pkg::SIZE_BYTE};
          n.wd = {24'h0, b[7:0]};
        end
        1: begin
          w = {imm[11:5], r2, r1, 3'h1, imm[4:0], 7'h23};
          n.ea = {n.va ^ PA_XOR, sscx_pkg::SIZE_HALF};
          n.wd = {16'h0, b[15:0]};
        end
        2: begin w = {7'h00, r2, r1, 3'h1, rd, 7'h33}; n.data = a << b[4:0]; end
        3: begin w = {7'h00, r2, r1, 3'h2, rd, 7'h33}; n.data = {31'h0, $signed(a) < $signed(b)}; end
        4: begin w = {imm, r1, 3'h2, rd, 7'h13}; n.data = {31'h0, $signed(a) < $signed(sx)}; end
        default: begin w = {7'h20, r2, r1, 3'h1, rd, 7'h33}; n.ill = 1'b1; end
      endcase
      if (op < 2) begin
        n.st = (fs == 2'h0) ? 3 : int'(fs);
        n.fail = fs != 2'h0;
        n.ret = fs == 2'h0;
      end else if (op < 5) begin
        n.ret = 1'b1;
        n.we = rd != 5'h0;
      end
      issue(w, n);
    end
    @(negedge clk) valid = 1'b0;
    repeat (30) @(negedge clk);
    check("notes left", notes.size(), 35'h0);
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
